// *** core/gpf_pkg.sv ***
// shared constants and types of the gpio filter and output data block
package gpf_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int unsigned LINES    = 32;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned BE_W     = 4;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_LINE_OWN_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_LINE_OWN_DISABLE  = 8'h04;
    localparam logic [7:0] OFS_LINE_OWN_STATUS   = 8'h08;
    localparam logic [7:0] OFS_OUTPUT_ENABLE     = 8'h10;
    localparam logic [7:0] OFS_OUTPUT_DISABLE    = 8'h14;
    localparam logic [7:0] OFS_OUTPUT_DIR_STATUS = 8'h18;
    localparam logic [7:0] OFS_FILTER_ENABLE     = 8'h20;
    localparam logic [7:0] OFS_FILTER_DISABLE    = 8'h24;
    localparam logic [7:0] OFS_FILTER_STATUS     = 8'h28;
    localparam logic [7:0] OFS_OUTPUT_DATA_SET   = 8'h30;
    localparam logic [7:0] OFS_OUTPUT_DATA_CLEAR = 8'h34;
    localparam logic [7:0] OFS_OUTPUT_DATA_STAT  = 8'h38;
    localparam logic [7:0] OFS_PIN_DATA_STATUS   = 8'h3c;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_LINE_OWN    = 32'h0000_0000;
    localparam logic [31:0] RST_OUTPUT_DIR  = 32'h0000_0000;
    localparam logic [31:0] RST_FILTER      = 32'h0000_0000;
    localparam logic [31:0] RST_OUTPUT_DATA = 32'h0000_0000;
    localparam logic [31:0] RD_ZERO         = 32'h0000_0000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    // cycles an input must stay at a new level before the filter passes it
    // two would pass anything the synchroniser lets through
    localparam int unsigned FILT_CYCLES = 3;
    localparam int unsigned FILT_CNT_W  = 2;
    localparam logic [FILT_CNT_W-1:0] FILT_LAST =
        FILT_CNT_W'(FILT_CYCLES - 1);
    localparam logic [FILT_CNT_W-1:0] FILT_ZERO = '0;

    // ------------------------------------------------------------------
    // bus request carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [BE_W-1:0]   byteenable;
    } gpf_av_req_t;

    // pin side carrier
    typedef struct packed {
        logic [LINES-1:0] out;
        logic [LINES-1:0] oe;
    } gpf_pad_drv_t;

endpackage

// *** core/gpf_sync.sv ***
// three-stage synchroniser for one pin input
`timescale 1ns/1ps
module gpf_sync (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic async_in,
    output logic      level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ------------------------------------------------------------------
    // capture chain
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ------------------------------------------------------------------
    // accept a change once stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            level_q <= 1'b0;
        end else if (ce && (s2_q == s3_q)) begin
            level_q <= s3_q;
        end
    end

endmodule

// *** core/gpf_glitch.sv ***
// selectable glitch filter for one synchronised input line
`timescale 1ns/1ps
module gpf_glitch (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic level_in,
    output logic      level_q
);

    logic [gpf_pkg::FILT_CNT_W-1:0] cnt_q;

    // ------------------------------------------------------------------
    // pass through, or wait for a stable new level
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q   <= gpf_pkg::FILT_ZERO;
            level_q <= 1'b0;
        end else if (ce) begin
            if (!enable || level_in == level_q) begin
                cnt_q   <= gpf_pkg::FILT_ZERO;
                level_q <= level_in;
            end else if (cnt_q == gpf_pkg::FILT_LAST) begin
                cnt_q   <= gpf_pkg::FILT_ZERO;
                level_q <= level_in;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule

// *** core/gpf_top.sv ***
// 32-line gpio port: ownership, direction, glitch filters and output data
//
// Function
// [R1] The output direction status reads 1 per output line, 0 per input, reset 0.
// [R2] A line's output enable reaches its pin only while the controller owns it.
// [R3] Writing 1 to a filter enable bit turns that line's filter on, 0 does nothing.
// [R4] Writing 1 to a filter disable bit turns that line's filter off, 0 does nothing.
// [R5] Filter enable and disable act whoever owns the pin.
// [R6] The filter status reads 1 per selected filter, follows every write, reset 0.
// [R7] A selected filter sits on the input feeding both controller and peripheral.
// [R8] Writing 1 to an output data set bit sets that line's data latch.
// [R9] Writing 1 to an output data clear bit clears that line's data latch.
// [R10] The data latch drives a pin only if output enabled and controller owned.
// [R11] Ownership is given to the controller by an enable write, back by a disable.
// [R12] The output enable latch is set by the enable and cleared by the disable write.
// [R13] The output data status reads back each line's data latch.
// [R14] Every register is 32 bits, bit n for line n.
// [R15] Write-only registers read as zero with no side effect.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module gpf_top (
    input  wire logic                        sys_clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // avalon-mm slave
    input  wire logic [gpf_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [gpf_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [gpf_pkg::BE_W-1:0]    avs_byteenable,
    output logic [gpf_pkg::DATA_W-1:0]       avs_readdata,
    output logic                             avs_waitrequest,
    // pins
    input  wire logic [gpf_pkg::LINES-1:0]   pad_in,
    output logic [gpf_pkg::LINES-1:0]        pad_out,
    output logic [gpf_pkg::LINES-1:0]        pad_oe,
    // peripheral side
    input  wire logic [gpf_pkg::LINES-1:0]   periph_out,
    input  wire logic [gpf_pkg::LINES-1:0]   periph_oe,
    output logic [gpf_pkg::LINES-1:0]        periph_in
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    gpf_pkg::gpf_av_req_t            req;
    gpf_pkg::gpf_pad_drv_t           drv_d;
    gpf_pkg::gpf_pad_drv_t           drv_q;

    logic                            ack_q;
    logic [gpf_pkg::DATA_W-1:0]      rdata_q;
    logic [gpf_pkg::DATA_W-1:0]      rdata_d;
    logic [gpf_pkg::DATA_W-1:0]      wmask;
    logic [gpf_pkg::DATA_W-1:0]      wbits;
    logic                            wr_commit;

    logic [gpf_pkg::LINES-1:0]       own_q;
    logic [gpf_pkg::LINES-1:0]       oe_q;
    logic [gpf_pkg::LINES-1:0]       filt_q;
    logic [gpf_pkg::LINES-1:0]       odata_q;
    logic [gpf_pkg::LINES-1:0]       sync_lvl;
    logic [gpf_pkg::LINES-1:0]       filt_lvl;
    logic [gpf_pkg::LINES-1:0]       periph_in_q;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic hit(
        input logic [gpf_pkg::ADDR_W-1:0] addr,
        input logic [gpf_pkg::ADDR_W-1:0] ofs
    );
        hit = (addr == ofs);
    endfunction

    function automatic logic [gpf_pkg::DATA_W-1:0] be_mask(
        input logic [gpf_pkg::BE_W-1:0] be
    );
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [gpf_pkg::LINES-1:0] set_clr(
        input logic [gpf_pkg::LINES-1:0] cur,
        input logic                      do_set,
        input logic                      do_clr,
        input logic [gpf_pkg::LINES-1:0] bits
    );
        logic [gpf_pkg::LINES-1:0] res;
        res = cur;
        if (do_set) begin
            res = res | bits;
        end
        if (do_clr) begin
            res = res & ~bits;
        end
        set_clr = res;
    endfunction

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    always_comb begin
        req.read       = avs_read;
        req.write      = avs_write;
        req.address    = avs_address;
        req.writedata  = avs_writedata;
        req.byteenable = avs_byteenable;
    end

    // one wait cycle, then the request completes
    assign avs_waitrequest = (req.read | req.write) & ~ack_q;
    assign avs_readdata    = rdata_q;

    // writes land at the edge where waitrequest is sampled low
    assign wr_commit = ce & ack_q & req.write;
    assign wmask     = be_mask(req.byteenable);
    assign wbits     = req.writedata & wmask;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= (req.read | req.write) & ~ack_q;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = gpf_pkg::RD_ZERO; // R15
        if (hit(req.address, gpf_pkg::OFS_LINE_OWN_STATUS)) begin
            rdata_d = own_q;
        end else if (hit(req.address, gpf_pkg::OFS_OUTPUT_DIR_STATUS)) begin
            rdata_d = oe_q; // R1 R14
        end else if (hit(req.address, gpf_pkg::OFS_FILTER_STATUS)) begin
            rdata_d = filt_q; // R6
        end else if (hit(req.address, gpf_pkg::OFS_OUTPUT_DATA_STAT)) begin
            rdata_d = odata_q; // R13
        end else if (hit(req.address, gpf_pkg::OFS_PIN_DATA_STATUS)) begin
            rdata_d = filt_lvl;
        end
        // write-only and unmapped offsets fall through to zero
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= gpf_pkg::RD_ZERO;
        end else if (ce && req.read && !ack_q) begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // line ownership
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            own_q <= gpf_pkg::RST_LINE_OWN;
        end else if (wr_commit) begin
            own_q <= set_clr(own_q,
                hit(req.address, gpf_pkg::OFS_LINE_OWN_ENABLE),
                hit(req.address, gpf_pkg::OFS_LINE_OWN_DISABLE),
                wbits); // R11
        end
    end

    // ------------------------------------------------------------------
    // output enable latch
    // ------------------------------------------------------------------
    // stored even while a peripheral owns the line
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oe_q <= gpf_pkg::RST_OUTPUT_DIR;
        end else if (wr_commit) begin
            oe_q <= set_clr(oe_q,
                hit(req.address, gpf_pkg::OFS_OUTPUT_ENABLE),
                hit(req.address, gpf_pkg::OFS_OUTPUT_DISABLE),
                wbits); // R12
        end
    end

    // ------------------------------------------------------------------
    // glitch filter selection
    // ------------------------------------------------------------------
    // ownership plays no part here
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            filt_q <= gpf_pkg::RST_FILTER;
        end else if (wr_commit) begin
            filt_q <= set_clr(filt_q,
                hit(req.address, gpf_pkg::OFS_FILTER_ENABLE),   // R3
                hit(req.address, gpf_pkg::OFS_FILTER_DISABLE),  // R4
                wbits); // R5
        end
    end

    // ------------------------------------------------------------------
    // output data latch
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            odata_q <= gpf_pkg::RST_OUTPUT_DATA;
        end else if (wr_commit) begin
            odata_q <= set_clr(odata_q,
                hit(req.address, gpf_pkg::OFS_OUTPUT_DATA_SET),   // R8
                hit(req.address, gpf_pkg::OFS_OUTPUT_DATA_CLEAR), // R9
                wbits);
        end
    end

    // ------------------------------------------------------------------
    // input path per line
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < gpf_pkg::LINES; gi++) begin : g_line
            gpf_sync u_sync (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .ce       (ce),
                .async_in (pad_in[gi]),
                .level_q  (sync_lvl[gi])
            );
            gpf_glitch u_glitch (
                .sys_clk  (sys_clk),
                .resetn   (resetn),
                .ce       (ce),
                .enable   (filt_q[gi]),
                .level_in (sync_lvl[gi]),
                .level_q  (filt_lvl[gi])
            );
        end
    endgenerate

    // peripheral sees the filtered level, held low while controller owns
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            periph_in_q <= '0;
        end else if (ce) begin
            periph_in_q <= filt_lvl & ~own_q; // R7
        end
    end

    assign periph_in = periph_in_q;

    // ------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------
    always_comb begin
        drv_d.oe  = (own_q & oe_q) | (~own_q & periph_oe);      // R2
        drv_d.out = (own_q & odata_q) | (~own_q & periph_out);  // R10
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            drv_q <= '0;
        end else if (ce) begin
            drv_q <= drv_d;
        end
    end

    assign pad_out = drv_q.out;
    assign pad_oe  = drv_q.oe;

endmodule

// *** dv/gpf_top_asserts.sv ***
// concurrent port checks of the gpio filter and output data block
`timescale 1ns/1ps
module gpf_top_asserts (
    input wire logic                       sys_clk,
    input wire logic                       resetn,
    input wire logic                       ce,
    input wire logic [gpf_pkg::ADDR_W-1:0] avs_address,
    input wire logic                       avs_read,
    input wire logic                       avs_write,
    input wire logic [gpf_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [gpf_pkg::BE_W-1:0]   avs_byteenable,
    input wire logic [gpf_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                       avs_waitrequest,
    input wire logic [gpf_pkg::LINES-1:0]  pad_in,
    input wire logic [gpf_pkg::LINES-1:0]  pad_out,
    input wire logic [gpf_pkg::LINES-1:0]  pad_oe,
    input wire logic [gpf_pkg::LINES-1:0]  periph_out,
    input wire logic [gpf_pkg::LINES-1:0]  periph_oe,
    input wire logic [gpf_pkg::LINES-1:0]  periph_in
);
    logic req;
    logic wr_done;
    assign req     = avs_read | avs_write;
    assign wr_done = avs_write & ~avs_waitrequest;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    wait_state_a: assert property (req && avs_waitrequest && ce
        |=> !avs_waitrequest) else $error("wait state too long");
    first_wait_a: assert property ($rose(req) && ce
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("request not held one cycle");
    idle_nowait_a: assert property (!req |-> !avs_waitrequest)
        else $error("waitrequest without request");
    rdata_hold_a: assert property ($changed(avs_readdata)
        |-> $past(avs_read && avs_waitrequest))
        else $error("read data moved without a read");
    wo_read_zero_a: assert property (avs_read && !avs_waitrequest
        && (avs_address inside {8'h20, 8'h24, 8'h30, 8'h34, 8'h1c})
        |-> avs_readdata == 32'h0) else $error("write-only read not zero");

    // ------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------
    reset_quiet_a: assert property ($rose(resetn) |-> pad_out == '0
        && pad_oe == '0 && periph_in == '0 && avs_readdata == '0)
        else $error("outputs not cleared by reset");
    pin_out_cause_a: assert property ($changed(pad_out)
        |-> ($past(periph_out) != $past(periph_out, 2))
        || $past(wr_done, 2) || $past(!resetn))
        else $error("pin data moved without cause");
    pin_oe_cause_a: assert property ($changed(pad_oe)
        |-> ($past(periph_oe) != $past(periph_oe, 2))
        || $past(wr_done, 2) || $past(!resetn))
        else $error("pin enable moved without cause");

    write_c: cover property (wr_done);
    read_c: cover property (avs_read && !avs_waitrequest
        && avs_readdata != '0);
    periph_c: cover property ($changed(periph_in));
endmodule

// *** dv/gpf_pin_model.sv ***
// external circuit on the pins: bench levels where no one drives
`timescale 1ns/1ps
module gpf_pin_model (
    input  wire logic [gpf_pkg::LINES-1:0] pad_out,
    input  wire logic [gpf_pkg::LINES-1:0] pad_oe,
    input  wire logic [gpf_pkg::LINES-1:0] ext_lvl,
    output logic      [gpf_pkg::LINES-1:0] pad_in
);
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule

// *** dv/testbench.sv ***
// self-checking bench of the gpio filter and output data block
`timescale 1ns/1ps
module testbench;
    logic        sys_clk        = 1'b0;
    logic        resetn         = 1'b0;
    logic [7:0]  avs_address    = 8'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] periph_out     = 32'h0;
    logic [31:0] periph_oe      = 32'h0;
    logic [31:0] ext_lvl        = 32'h0;
    logic [31:0] avs_readdata, pad_in, pad_out, pad_oe, periph_in;
    logic        avs_waitrequest;
    logic [31:0] m_own, m_oe, m_filt, m_dat, rd, v, seen;
    logic [7:0]  a;
    logic [3:0]  be;
    logic [7:0]  wr_tab [8] = '{8'h00, 8'h04, 8'h10, 8'h14,
                                8'h20, 8'h24, 8'h30, 8'h34};
    int          errors  = 0;
    int          checked = 0;
    int          seed    = 32'h7c209a9e;

    always #20 sys_clk = ~sys_clk;

    gpf_top i_gpf_top (.sys_clk, .resetn, .ce(1'b1), .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .pad_in, .pad_out, .pad_oe,
        .periph_out, .periph_oe, .periph_in);
    gpf_pin_model u_pins (.pad_out, .pad_oe, .ext_lvl, .pad_in);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] ad,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= ad;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        q = avs_readdata;
        if (n == 50) begin
            errors++;
            $display("[FAIL] %0t bus answer missing", $time);
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic logic [31:0] msk(input logic [3:0] b);
        msk = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction

    // expected register model
    task automatic upd(input logic [7:0] ad, input logic [31:0] d);
        case (ad)
            8'h00: m_own = m_own | d;
            8'h04: m_own = m_own & ~d;
            8'h10: m_oe = m_oe | d;
            8'h14: m_oe = m_oe & ~d;
            8'h20: m_filt = m_filt | d;
            8'h24: m_filt = m_filt & ~d;
            8'h30: m_dat = m_dat | d;
            8'h34: m_dat = m_dat & ~d;
            default: ;
        endcase
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, rd);
        upd(ad, d);
    endtask

    task automatic status();
        bus(1'b0, 8'h08, 32'h0, rd);
        check(rd, m_own);
        bus(1'b0, 8'h18, 32'h0, rd);
        check(rd, m_oe);
        bus(1'b0, 8'h28, 32'h0, rd);
        check(rd, m_filt);
        bus(1'b0, 8'h38, 32'h0, rd);
        check(rd, m_dat);
    endtask

    initial begin
        m_own = gpf_pkg::RST_LINE_OWN;
        m_oe = gpf_pkg::RST_OUTPUT_DIR;
        m_filt = gpf_pkg::RST_FILTER;
        m_dat = gpf_pkg::RST_OUTPUT_DATA;
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        status();
        $display("reset values done");
        for (int i = 0; i < 40; i++) begin
            a = wr_tab[$unsigned($random(seed)) % 8];
            v = $random(seed);
            be = $random(seed);
            avs_byteenable <= be;
            periph_out <= $random(seed);
            periph_oe <= $random(seed);
            wr(a, v & msk(be));
            repeat (3) @(posedge sys_clk);
            check(pad_oe, (m_own & m_oe) | (~m_own & periph_oe));
            check(pad_out, (m_own & m_dat) | (~m_own & periph_out));
        end
        avs_byteenable <= 4'hf;
        status();
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, wr_tab[i], 32'h0, rd);
            check(rd, gpf_pkg::RD_ZERO);
        end
        bus(1'b0, 8'h1c, 32'h0, rd);
        check(rd, 32'h0);
        status();
        $display("random register traffic done");
        periph_oe <= 32'h0;
        wr(8'h04, 32'hffff_ffff);
        wr(8'h00, 32'h0000_0004);
        wr(8'h20, 32'h0000_0005);
        wr(8'h24, 32'h0000_0002);
        status();
        repeat (8) @(posedge sys_clk);
        seen = 32'h0;
        ext_lvl <= 32'h7;
        repeat (2) @(posedge sys_clk);
        ext_lvl <= 32'h0;
        repeat (12) begin
            @(posedge sys_clk);
            seen = seen | periph_in;
        end
        check(seen & 32'h7, 32'h2);
        seen = 32'h0;
        ext_lvl <= 32'h7;
        repeat (12) begin
            @(posedge sys_clk);
            seen = seen | periph_in;
        end
        check(seen & 32'h7, 32'h3);
        bus(1'b0, 8'h3c, 32'h0, rd);
        check(rd & 32'h3, 32'h3);
        $display("glitch filter done");
        test_done();
    end

    initial begin
        #(40 * 5000);
        errors++;
        $display("[FAIL] %0t run did not finish", $time);
        test_done();
    end
endmodule

bind gpf_top gpf_top_asserts u_chk (.sys_clk, .resetn, .ce, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .pad_in, .pad_out, .pad_oe, .periph_out, .periph_oe,
    .periph_in);
